//--- adc_link_pkg.sv
// constants shared by the converter end and the serial host end
package adc_link_pkg;
  localparam int          CLK_NS          = 100;
  localparam int          REF_WAIT_NS     = 65000;
  localparam int          REF_WAIT_CYC    = (REF_WAIT_NS + CLK_NS - 1) / CLK_NS;
  localparam int          CS_GAP_MAX_NS   = 100000;
  localparam int          CS_GAP_MAX_CYC  = CS_GAP_MAX_NS / CLK_NS;
  localparam logic [2:0]  BIT_LAST        = 3'h7;
  localparam logic [2:0]  BIT_SECOND      = 3'h1;
  localparam logic [3:0]  FIRST_BYTE_BITS = 4'h8;
  localparam logic [4:0]  ENTRY_BITS      = 5'h10;
  localparam logic [7:0]  CONV_CLKS       = 8'h10;
  localparam logic [7:0]  TEMP_CLKS       = 8'hC0;
  localparam logic [7:0]  TEMP_OUT_CLKS   = 8'h10;
  localparam logic [3:0]  LEAD_ZEROS      = 4'h0;
  localparam logic [1:0]  TAIL_ZEROS      = 2'h0;
  localparam logic [9:0]  BIPOLAR_FLIP    = 10'h200;
  localparam logic [1:0]  SETUP_SEL       = 2'h1;
  localparam int          SET_CLK_HI      = 5;
  localparam int          SET_CLK_LO      = 4;
  localparam int          SET_REF_HI      = 3;
  localparam int          SET_REF_LO      = 2;
  localparam int          SET_BIPOLAR     = 1;
  localparam logic [5:0]  SETUP_RST       = 6'h20;
  localparam logic [1:0]  CLK_MODE_EXT    = 2'h3;
  localparam logic [1:0]  REF_MODE_WAKE   = 2'h0;
  localparam int          CMD_CONV_BIT    = 7;
  localparam int          CMD_TEMP_BIT    = 0;
  localparam logic [11:0] REG_CTRL        = 12'h000;
  localparam logic [11:0] REG_STATUS      = 12'h004;
  localparam logic [11:0] REG_RESULT      = 12'h008;
  localparam logic [11:0] REG_IRQ_STAT    = 12'h00C;
  localparam logic [11:0] REG_IRQ_MASK    = 12'h010;
  localparam int          CTRL_NZERO_LO   = 8;
  localparam int          CTRL_NZERO_HI   = 12;
  localparam int          CTRL_REF_WAIT   = 16;
  localparam int          CTRL_WAIT_EOC   = 17;
  typedef enum logic [1:0] {ST_IDLE, ST_EOC, ST_SHIFT, ST_GAP} host_state_t;
endpackage

//--- adc_link_if.sv
// serial link between the converter and its host
`timescale 1ns/1ps
`default_nettype none
interface adc_link_if;
  logic cs_n;
  logic sclk;
  logic din;
  logic dout;
  logic eoc_n;
  modport dev  (input cs_n, input sclk, input din, output dout, output eoc_n);
  modport host (output cs_n, output sclk, output din, input dout, input eoc_n);
endinterface
`default_nettype wire

//--- adc_dev_end.sv
// converter end: command decode, externally clocked conversion, result fifo readout
//
// How it works
// (RULE1) conversion byte starts one sclk-clocked conversion
// (RULE2) no scan or averaging; result shifts during conversion
// (RULE3) host gives command then sixteen clocks
// (RULE4) host keeps mid-conversion chip-select gap short
// (RULE5) host interleaves a zero byte between commands
// (RULE6) host waits with chip select high for reference
// (RULE7) temperature: 192 clocks, result in last two bytes
// (RULE8) short first byte: next byte continues, rest dropped
// (RULE9) short second byte drops rest of entry
// (RULE10) other entries stay readable; host ignores lead nibble
// (RULE11) partial register write keeps unwritten low bits
// (RULE12) host waits for end-of-conversion before chip select
// (RULE13) binary codes, temperature in eighths of a degree
// (RULE14) sample input on sclk rise, change output on fall
// (RULE15) unipolar straight binary, bipolar two's complement
// (RULE16) results leave most significant bit first
`timescale 1ns/1ps
`default_nettype none
module adc_dev_end #(
  parameter int DEPTH = 16
) (
  input  wire logic          mclk,
  input  wire logic          rst,
  adc_link_if.dev            lnk,
  input  wire logic [9:0]    sample_code,
  input  wire logic [11:0]   temp_code,
  input  wire logic          fifo_push,
  input  wire logic [9:0]    fifo_code,
  output logic               conv_start,
  output logic [5:0]         setup_out
);
  import adc_link_pkg::*;

  localparam int AW = $clog2(DEPTH);

  logic              sclk_q_ff;
  logic              cs_q_ff;
  logic [2:0]        in_cnt_ff;
  logic [6:0]        in_sh_ff;
  logic              wr_setup_ff;
  logic [5:0]        setup_ff;
  logic              conv_on_ff;
  logic              temp_ff;
  logic [7:0]        conv_cnt_ff;
  logic [15:0]       out_sh_ff;
  logic              dout_ff;
  logic              eoc_n_ff;
  logic              conv_start_ff;
  logic [9:0]        mem [DEPTH];
  logic [AW-1:0]     wr_ptr_ff;
  logic [AW-1:0]     rd_ptr_ff;
  logic [AW:0]       cnt_ff;
  logic [4:0]        pos_ff;
  logic [4:0]        lim_ff;
  logic              active;
  logic              rise;
  logic              fall;
  logic              cs_rise;
  logic              cs_fall;
  logic              cmd_ok;
  logic              conv_last;
  logic              fifo_rd;
  logic              fifo_cut;
  logic              pop;
  logic              push;
  logic [9:0]        code_fmt;
  logic [15:0]       entry_word;
  logic [7:0]        conv_lim;
  logic [4:0]        nxt_pos;

  // link pins are synchronous to mclk, so edges come from a one-cycle delay
  assign active  = ~lnk.cs_n;
  assign rise    = active & lnk.sclk & ~sclk_q_ff; // [RULE14]
  assign fall    = active & ~lnk.sclk & sclk_q_ff; // [RULE14]
  assign cs_rise = lnk.cs_n & ~cs_q_ff;
  assign cs_fall = ~lnk.cs_n & cs_q_ff;

  always_ff @(posedge mclk) begin
    if (rst) begin
      sclk_q_ff <= 1'b0;
      cs_q_ff   <= 1'b1;
    end else begin
      sclk_q_ff <= lnk.sclk;
      cs_q_ff   <= lnk.cs_n;
    end
  end

  // input byte framing restarts with every chip-select assertion
  always_ff @(posedge mclk) begin
    if (rst || !active) begin
      in_cnt_ff   <= 3'h0;
      in_sh_ff    <= 7'h00;
      wr_setup_ff <= 1'b0;
    end else if (rise) begin
      in_cnt_ff <= in_cnt_ff + 3'h1;
      in_sh_ff  <= {in_sh_ff[5:0], lnk.din};
      if (in_cnt_ff == BIT_SECOND) begin
        wr_setup_ff <= ({in_sh_ff[0], lnk.din} == SETUP_SEL);
      end else if (in_cnt_ff == BIT_LAST) begin
        wr_setup_ff <= 1'b0;
      end
    end
  end

  // each setup bit lands as it arrives, so a cut write leaves the low bits alone
  always_ff @(posedge mclk) begin
    if (rst) begin
      setup_ff <= SETUP_RST;
    end else if (rise && wr_setup_ff) begin
      setup_ff[3'(BIT_LAST - in_cnt_ff)] <= lnk.din; // [RULE11]
    end
  end

  assign cmd_ok = rise && (in_cnt_ff == BIT_LAST) && in_sh_ff[CMD_CONV_BIT-1]
                  && (setup_ff[SET_CLK_HI:SET_CLK_LO] == CLK_MODE_EXT); // [RULE1]

  // bipolar codes arrive offset binary from the converter core
  assign code_fmt = setup_ff[SET_BIPOLAR] ? (sample_code ^ BIPOLAR_FLIP) : sample_code; // [RULE15] [RULE13]
  assign conv_lim = temp_ff ? TEMP_CLKS : CONV_CLKS; // [RULE7]
  assign conv_last = fall && conv_on_ff && (conv_cnt_ff == conv_lim - 8'h01);

  // a new command during the tail of a result restarts the count, which is
  // what makes sixteen clocks per conversion work with one zero byte between
  always_ff @(posedge mclk) begin
    if (rst) begin
      conv_on_ff  <= 1'b0;
      temp_ff     <= 1'b0;
      conv_cnt_ff <= 8'h00;
      out_sh_ff   <= 16'h0000;
    end else if (cmd_ok) begin
      conv_on_ff  <= 1'b1; // [RULE1] [RULE2]
      temp_ff     <= lnk.din;
      conv_cnt_ff <= 8'h00;
      if (lnk.din) begin
        out_sh_ff <= {LEAD_ZEROS, temp_code}; // [RULE13]
      end else begin
        out_sh_ff <= {LEAD_ZEROS, code_fmt, TAIL_ZEROS};
      end
    end else if (fall && conv_on_ff) begin
      conv_cnt_ff <= conv_cnt_ff + 8'h01; // [RULE1]
      if (!temp_ff || conv_cnt_ff >= TEMP_CLKS - TEMP_OUT_CLKS) begin
        out_sh_ff <= {out_sh_ff[14:0], 1'b0}; // [RULE16]
      end
      if (conv_last) begin
        conv_on_ff <= 1'b0;
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      conv_start_ff <= 1'b0;
    end else begin
      conv_start_ff <= cmd_ok;
    end
  end

  // result fifo, entries are 4 zero bits, the code, then 2 zero bits
  assign entry_word = {LEAD_ZEROS, mem[rd_ptr_ff], TAIL_ZEROS}; // [RULE10]
  // a fifo bit is used up at the rise on which the host samples it
  assign fifo_rd    = rise && !conv_on_ff && (cnt_ff != '0);
  assign fifo_cut   = cs_rise && !conv_on_ff && (cnt_ff != '0) && (pos_ff != 5'h00);
  assign nxt_pos    = pos_ff + 5'h01;
  assign pop        = (fifo_rd && nxt_pos == lim_ff)
                      || (fifo_cut && pos_ff > 5'(FIRST_BYTE_BITS)); // [RULE9]
  assign push       = fifo_push && (cnt_ff != (AW+1)'(DEPTH));

  always_ff @(posedge mclk) begin
    if (push) begin
      mem[wr_ptr_ff] <= fifo_code;
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      wr_ptr_ff <= '0;
      rd_ptr_ff <= '0;
      cnt_ff    <= '0;
    end else begin
      if (push) begin
        wr_ptr_ff <= wr_ptr_ff + 1'b1;
      end
      if (pop) begin
        rd_ptr_ff <= rd_ptr_ff + 1'b1; // [RULE10]
      end
      cnt_ff <= cnt_ff + (AW+1)'(push) - (AW+1)'(pop);
    end
  end

  // read position within the head entry and where that entry ends
  always_ff @(posedge mclk) begin
    if (rst) begin
      pos_ff <= 5'h00;
      lim_ff <= ENTRY_BITS;
    end else if (pop) begin
      pos_ff <= 5'h00;
      lim_ff <= ENTRY_BITS;
    end else if (fifo_rd) begin
      pos_ff <= nxt_pos;
    end else if (fifo_cut && pos_ff < 5'(FIRST_BYTE_BITS)) begin
      lim_ff <= pos_ff + 5'(FIRST_BYTE_BITS); // [RULE8]
    end
  end

  // data out moves only after a falling sclk edge or, for a fifo head bit, a chip-select fall
  always_ff @(posedge mclk) begin
    if (rst) begin
      dout_ff <= 1'b0;
    end else if (fall && conv_on_ff) begin
      if (!temp_ff || conv_cnt_ff >= TEMP_CLKS - TEMP_OUT_CLKS) begin
        dout_ff <= out_sh_ff[15]; // [RULE2] [RULE7] [RULE14]
      end else begin
        dout_ff <= 1'b0;
      end
    end else if ((fall || cs_fall) && !conv_on_ff && (cnt_ff != '0)) begin
      // head bit stands before the first rise, so byte framing matches the host's
      dout_ff <= entry_word[4'(15 - pos_ff)]; // [RULE8] [RULE16]
    end else if (fall) begin
      dout_ff <= 1'b0;
    end
  end

  // end-of-conversion falls on a finished result; a new result beats a
  // chip-select fall in the same cycle
  always_ff @(posedge mclk) begin
    if (rst) begin
      eoc_n_ff <= 1'b1;
    end else if (conv_last || push) begin
      eoc_n_ff <= 1'b0;
    end else if (cs_fall) begin
      eoc_n_ff <= 1'b1;
    end
  end

  assign lnk.dout   = dout_ff;
  assign lnk.eoc_n  = eoc_n_ff;
  assign conv_start = conv_start_ff;
  assign setup_out  = setup_ff;
endmodule // adc_dev_end
`default_nettype wire

//--- adc_host_end.sv
// host end: apb-controlled serial master that issues commands and collects results
`timescale 1ns/1ps
`default_nettype none
module adc_host_end #(
  parameter int HALF   = 2,
  parameter int REF_WT = adc_link_pkg::REF_WAIT_CYC
) (
  input  wire logic          mclk,
  input  wire logic          rst,
  adc_link_if.host           lnk,
  input  wire logic [11:0]   paddr,
  input  wire logic          psel,
  input  wire logic          penable,
  input  wire logic          pwrite,
  input  wire logic [31:0]   pwdata,
  output logic [31:0]        prdata,
  output logic               pready,
  output logic               pslverr,
  output logic               irq
);
  import adc_link_pkg::*;

  host_state_t       state_ff;
  logic [17:0]       ctrl_ff;
  logic [11:0]       result_ff;
  logic              irq_st_ff;
  logic              irq_mask_ff;
  logic              irq_ff;
  logic [31:0]       prdata_ff;
  logic              pready_ff;
  logic              pslverr_ff;
  logic              cs_n_ff;
  logic              sclk_ff;
  logic              din_ff;
  logic [7:0]        div_ff;
  logic [8:0]        bit_ff;
  logic [9:0]        gap_ff;
  logic              gapped_ff;
  logic [7:0]        tx_sh_ff;
  logic [15:0]       rx_sh_ff;
  logic              wr;
  logic              go;
  logic              tick;
  logic              done;
  logic [8:0]        tot_bits;
  logic              mapped;

  // mclk is slow against the device sampling, so half periods are whole cycles
  assign tick     = (div_ff == 8'(HALF - 1));
  assign tot_bits = {1'b0, ctrl_ff[CTRL_NZERO_HI:CTRL_NZERO_LO], 3'h0} + 9'h008; // [RULE3] [RULE7]
  assign wr       = psel && penable && pwrite && pready_ff;
  assign go       = wr && (paddr == REG_CTRL) && (state_ff == ST_IDLE);
  assign done     = (state_ff == ST_SHIFT) && tick && sclk_ff && (bit_ff == tot_bits);
  assign mapped   = (paddr == REG_CTRL) || (paddr == REG_STATUS) || (paddr == REG_RESULT)
                    || (paddr == REG_IRQ_STAT) || (paddr == REG_IRQ_MASK);

  // zero-wait slave: pready rises in the first access cycle
  always_ff @(posedge mclk) begin
    if (rst) begin
      pready_ff  <= 1'b0;
      pslverr_ff <= 1'b0;
      prdata_ff  <= 32'h0000_0000;
    end else begin
      pready_ff  <= psel && !penable;
      pslverr_ff <= psel && !penable && !mapped;
      if (psel && !penable && !pwrite) begin
        unique case (paddr)
          REG_CTRL:     prdata_ff <= {14'h0000, ctrl_ff};
          REG_STATUS:   prdata_ff <= {30'h0000_0000, ~lnk.eoc_n, state_ff != ST_IDLE};
          REG_RESULT:   prdata_ff <= {20'h0_0000, result_ff};
          REG_IRQ_STAT: prdata_ff <= {31'h0000_0000, irq_st_ff};
          REG_IRQ_MASK: prdata_ff <= {31'h0000_0000, irq_mask_ff};
          default:      prdata_ff <= 32'h0000_0000;
        endcase
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      ctrl_ff     <= 18'h0_0000;
      irq_mask_ff <= 1'b0;
    end else if (wr) begin
      if (go) begin
        ctrl_ff <= pwdata[17:0];
      end
      if (paddr == REG_IRQ_MASK) begin
        irq_mask_ff <= pwdata[0];
      end
    end
  end

  // a finished transfer wins over a one written to clear it
  always_ff @(posedge mclk) begin
    if (rst) begin
      irq_st_ff <= 1'b0;
      irq_ff    <= 1'b0;
    end else begin
      if (done) begin
        irq_st_ff <= 1'b1;
      end else if (wr && paddr == REG_IRQ_STAT && pwdata[0]) begin
        irq_st_ff <= 1'b0;
      end
      irq_ff <= irq_st_ff && irq_mask_ff;
    end
  end

  always_ff @(posedge mclk) begin
    if (rst || state_ff != ST_SHIFT || tick) begin
      div_ff <= 8'h00;
    end else begin
      div_ff <= div_ff + 8'h01;
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      state_ff  <= ST_IDLE;
      cs_n_ff   <= 1'b1;
      sclk_ff   <= 1'b0;
      din_ff    <= 1'b0;
      bit_ff    <= 9'h000;
      gap_ff    <= 10'h000;
      gapped_ff <= 1'b0;
      tx_sh_ff  <= 8'h00;
      rx_sh_ff  <= 16'h0000;
      result_ff <= 12'h000;
    end else begin
      unique case (state_ff)
        ST_IDLE: begin
          if (go) begin
            tx_sh_ff  <= pwdata[7:0];
            bit_ff    <= 9'h000;
            gapped_ff <= 1'b0;
            if (pwdata[CTRL_WAIT_EOC]) begin
              state_ff <= ST_EOC;
            end else begin
              cs_n_ff  <= 1'b0;
              din_ff   <= pwdata[CMD_CONV_BIT];
              state_ff <= ST_SHIFT;
            end
          end
        end
        ST_EOC: begin
          if (!lnk.eoc_n) begin
            cs_n_ff  <= 1'b0; // [RULE12]
            din_ff   <= tx_sh_ff[CMD_CONV_BIT];
            state_ff <= ST_SHIFT;
          end
        end
        ST_SHIFT: begin
          if (tick && !sclk_ff) begin
            sclk_ff  <= 1'b1;
            rx_sh_ff <= {rx_sh_ff[14:0], lnk.dout}; // [RULE14]
            bit_ff   <= bit_ff + 9'h001;
          end else if (tick) begin
            sclk_ff  <= 1'b0;
            tx_sh_ff <= {tx_sh_ff[6:0], 1'b0};
            din_ff   <= tx_sh_ff[6]; // [RULE14] [RULE5]
            if (done) begin
              cs_n_ff   <= 1'b1;
              result_ff <= rx_sh_ff[11:0]; // [RULE10]
              state_ff  <= ST_IDLE;
            end else if (bit_ff == 9'h008 && ctrl_ff[CTRL_REF_WAIT] && !gapped_ff) begin
              // select stays low this edge so the device still counts this fall
              gap_ff    <= 10'h000;
              gapped_ff <= 1'b1;
              state_ff  <= ST_GAP;
            end
          end
        end
        ST_GAP: begin
          gap_ff <= gap_ff + 10'h001;
          if (gap_ff == 10'(REF_WT)) begin
            cs_n_ff  <= 1'b0; // [RULE4] [RULE6]
            state_ff <= ST_SHIFT;
          end else begin
            cs_n_ff  <= 1'b1; // [RULE6]
          end
        end
      endcase
    end
  end

  assign lnk.cs_n = cs_n_ff;
  assign lnk.sclk = sclk_ff;
  assign lnk.din  = din_ff;
  assign prdata   = prdata_ff;
  assign pready   = pready_ff;
  assign pslverr  = pslverr_ff;
  assign irq      = irq_ff;
endmodule // adc_host_end
`default_nettype wire

//--- adc_link_chk.sv
// concurrent checks on the serial link between host end and converter end
`timescale 1ns/1ps
`default_nettype none
module adc_link_chk (
  input wire logic mclk,
  input wire logic rst,
  input wire logic cs_n,
  input wire logic sclk,
  input wire logic din,
  input wire logic dout,
  input wire logic eoc_n
);
  logic [2:0] bits_ff;
  logic       sclk_d_ff;

  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);

  always_ff @(posedge mclk) begin
    if (rst) begin
      sclk_d_ff <= 1'b0;
    end else begin
      sclk_d_ff <= sclk;
    end
  end

  // rises counted modulo 8: a frame may only close on a whole byte
  always_ff @(posedge mclk) begin
    if (rst) begin
      bits_ff <= 3'h0;
    end else if (sclk && !sclk_d_ff) begin
      bits_ff <= bits_ff + 3'h1;
    end
  end

  reset_idle_a: assert property ($fell(rst) |-> cs_n && !sclk && eoc_n && !dout)
    else $error("link not idle after reset");
  sclk_gated_a: assert property (cs_n |-> !sclk)
    else $error("serial clock high without chip select");
  sclk_high_a: assert property ($rose(sclk) |-> !cs_n ##1 sclk ##1 !sclk)
    else $error("serial clock high phase wrong");
  sclk_entry_a: assert property ($fell(cs_n) |-> !sclk ##1 !sclk)
    else $error("serial clock rose too soon after select");
  din_hold_a: assert property ($changed(din) |-> !sclk)
    else $error("input data moved while clock high");
  dout_hold_a: assert property ($rose(sclk) |=> $stable(dout))
    else $error("output data moved after clock rise");
  frame_bytes_a: assert property ($rose(cs_n) |-> bits_ff == 3'h0)
    else $error("frame closed off a byte boundary");
  eoc_clear_a: assert property ($fell(cs_n) |-> ##[0:3] eoc_n)
    else $error("end of conversion not cleared by select");
endmodule // adc_link_chk
`default_nettype wire

//--- test_adc_serial_clocked_conversion_ctrl.sv
// self-checking bench: host end and converter end joined over the serial link
`timescale 1ns/1ps
`default_nettype none
module test_adc_serial_clocked_conversion_ctrl;
  import adc_link_pkg::*;
  logic        mclk;
  logic        rst;
  logic [11:0] paddr;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        irq;
  logic [9:0]  sample_code;
  logic [11:0] temp_code;
  logic        fifo_push;
  logic [9:0]  fifo_code;
  logic        conv_start;
  logic [5:0]  setup_out;
  logic [31:0] rdat;
  logic        rerr;
  int          n_fail = 0;
  int          checks = 0;
  int          n_conv = 0;

  adc_link_if link ();
  // short reference wait keeps the run brief
  adc_host_end #(.HALF(2), .REF_WT(20)) i_adc_host_end (.mclk(mclk), .rst(rst), .lnk(link.host),
    .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .irq(irq));
  adc_dev_end #(.DEPTH(16)) i_adc_dev_end (.mclk(mclk), .rst(rst), .lnk(link.dev),
    .sample_code(sample_code), .temp_code(temp_code), .fifo_push(fifo_push),
    .fifo_code(fifo_code), .conv_start(conv_start), .setup_out(setup_out));
  adc_link_chk i_adc_link_chk (.mclk(mclk), .rst(rst), .cs_n(link.cs_n), .sclk(link.sclk),
    .din(link.din), .dout(link.dout), .eoc_n(link.eoc_n));

  initial begin
    mclk = 1'b0;
    forever #50 mclk = ~mclk;
  end

  always @(posedge mclk) begin
    if (conv_start === 1'b1) begin
      n_conv <= n_conv + 1;
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      n_fail++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // one apb transfer; entered just after a rising edge, leaves one idle edge behind
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge mclk);
    penable <= 1'b1;
    do begin
      @(posedge mclk);
    end while (pready !== 1'b1);
    rdat = prdata;
    rerr = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge mclk);
  endtask

  task automatic rd(input logic [11:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0000_0000);
    chk(rdat, exp);
  endtask

  // start a transfer and poll until the host end is idle again
  task automatic xfer(input logic [7:0] cmd, input logic [4:0] nz, input logic refw);
    apb(1'b1, REG_CTRL, {15'h0, refw, 3'h0, nz, cmd});
    do begin
      apb(1'b0, REG_STATUS, 32'h0000_0000);
    end while (rdat[0] !== 1'b0);
  endtask

  // irq is compared mid-cycle, then the bench returns to the rising edge
  task automatic irq_is(input logic e);
    @(negedge mclk);
    chk({31'h0, irq}, {31'h0, e});
    @(posedge mclk);
  endtask

  task automatic close_out;
    $display("checks=%0d n_fail=%0d", checks, n_fail);
    if (n_fail == 0 && checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge mclk);
    n_fail++;
    $display("watchdog expired at t=%0t", $time);
    close_out();
  end

  initial begin
    rst         = 1'b1;
    paddr       = 12'h000;
    psel        = 1'b0;
    penable     = 1'b0;
    pwrite      = 1'b0;
    pwdata      = 32'h0000_0000;
    sample_code = 10'h000;
    temp_code   = 12'h000;
    fifo_push   = 1'b0;
    fifo_code   = 10'h000;
    repeat (16) @(posedge mclk);
    rst <= 1'b0;
    @(posedge mclk);
    chk({26'h0, setup_out}, {26'h0, SETUP_RST});
    rd(REG_STATUS, 32'h0000_0000);
    rd(REG_RESULT, 32'h0000_0000);
    rd(REG_IRQ_STAT, 32'h0000_0000);
    $display("test reset done");
    // two entries read back in order, each whole
    fifo_code <= 10'h155;
    fifo_push <= 1'b1;
    @(posedge mclk);
    fifo_code <= 10'h0AA;
    @(posedge mclk);
    fifo_push <= 1'b0;
    @(posedge mclk);
    xfer(8'h00, 5'h01, 1'b0);
    rd(REG_RESULT, {20'h0, 10'h155, TAIL_ZEROS});
    xfer(8'h00, 5'h01, 1'b0);
    rd(REG_RESULT, {20'h0, 10'h0AA, TAIL_ZEROS});
    // one entry read over two frames of one byte each
    fifo_code <= 10'h3C7;
    fifo_push <= 1'b1;
    @(posedge mclk);
    fifo_push <= 1'b0;
    @(posedge mclk);
    xfer(8'h00, 5'h00, 1'b0);
    xfer(8'h00, 5'h00, 1'b0);
    rd(REG_RESULT, {20'h0, 10'h3C7, TAIL_ZEROS});
    $display("test fifo done");
    // conversion byte must be ignored outside clock mode 11
    sample_code <= 10'h2A5;
    xfer(8'h80, 5'h02, 1'b0);
    chk(n_conv, 32'h0000_0000);
    xfer(8'h74, 5'h00, 1'b0);
    chk({26'h0, setup_out}, 32'h0000_0034);
    xfer(8'h80, 5'h02, 1'b0);
    chk(n_conv, 32'h0000_0001);
    rd(REG_RESULT, {20'h0, 10'h2A5, TAIL_ZEROS});
    $display("test unipolar done");
    xfer(8'h76, 5'h00, 1'b0);
    chk({26'h0, setup_out}, 32'h0000_0036);
    xfer(8'h80, 5'h02, 1'b0);
    rd(REG_RESULT, {20'h0, 10'h2A5 ^ BIPOLAR_FLIP, TAIL_ZEROS});
    $display("test bipolar done");
    // temperature with a reference wait after the command byte
    temp_code <= 12'h5C3;
    xfer(8'h81, 5'h18, 1'b1);
    rd(REG_RESULT, {20'h0, 12'h5C3});
    $display("test temperature done");
    rd(REG_IRQ_STAT, 32'h0000_0001);
    irq_is(1'b0);
    apb(1'b1, REG_IRQ_MASK, 32'h0000_0001);
    irq_is(1'b1);
    apb(1'b1, REG_IRQ_STAT, 32'h0000_0001);
    irq_is(1'b0);
    rd(REG_IRQ_STAT, 32'h0000_0000);
    $display("test interrupt done");
    apb(1'b0, 12'h014, 32'h0000_0000);
    chk(rdat, 32'h0000_0000);
    chk({31'h0, rerr}, 32'h0000_0001);
    $display("test unmapped done");
    close_out();
  end
endmodule // test_adc_serial_clocked_conversion_ctrl
`default_nettype wire
